/* File: design/npm_pkg.sv */
package npm_pkg;
    // ------------
    // bus and data widths
    // ------------
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int NW = 16;

    // ------------
    // status point numbers
    // ------------
    localparam logic [AW-1:0] PT_MINOR_FLT   = 8'h12;
    localparam logic [AW-1:0] PT_MAJOR_FLT   = 8'h13;
    localparam logic [AW-1:0] PT_DIRECTION   = 8'h15;
    localparam logic [AW-1:0] PT_RUN_STATE   = 8'h17;
    localparam logic [AW-1:0] PT_ZERO_SPEED  = 8'h19;
    localparam logic [AW-1:0] PT_SPEED_AGREE = 8'h1a;
    localparam logic [AW-1:0] PT_READY       = 8'h1b;
    localparam logic [AW-1:0] PT_LOCAL_MODE  = 8'h1c;
    localparam logic [AW-1:0] PT_OUT_TERM1   = 8'h28;
    localparam logic [AW-1:0] PT_OUT_TERM2   = 8'h29;
    localparam logic [AW-1:0] PT_OUT_TERM3   = 8'h2a;
    localparam logic [AW-1:0] PT_SAFETY      = 8'h2b;
    localparam logic [AW-1:0] PT_IN_TERM1    = 8'h3a;
    localparam logic [AW-1:0] PT_IN_TERM2    = 8'h3b;
    localparam logic [AW-1:0] PT_IN_TERM3    = 8'h4a;
    localparam logic [AW-1:0] PT_IN_TERM4    = 8'h4e;
    localparam logic [AW-1:0] PT_OK_FAULT    = 8'h5d;
    localparam logic [AW-1:0] PT_COMM_ERR    = 8'h5f;
    localparam logic [AW-1:0] PT_IN_TERM5    = 8'h61;

    // ------------
    // status word and terminal monitor bit positions
    // ------------
    localparam int SW_RUN    = 0;
    localparam int SW_ZERO   = 1;
    localparam int SW_REV    = 2;
    localparam int SW_AGREE  = 4;
    localparam int SW_READY  = 5;
    localparam int SW_MINOR  = 6;
    localparam int SW_MAJOR  = 7;
    localparam int OT_BIT1   = 0;
    localparam int IT_BIT1   = 2;

    // ------------
    // command points: number, bit index in command register
    // ------------
    localparam int NCMD = 14;
    localparam logic [AW-1:0] PT_CMD_REV     = 8'h16;
    localparam logic [AW-1:0] PT_CMD_RUN     = 8'h18;
    localparam logic [AW-1:0] PT_CMD_DAYNGT  = 8'h1d;
    localparam logic [AW-1:0] PT_CMD_LOCK    = 8'h21;
    localparam logic [AW-1:0] PT_CMD_ENABLE  = 8'h23;
    localparam logic [AW-1:0] PT_CMD_MFI1    = 8'h2c;
    localparam logic [AW-1:0] PT_CMD_MFI5    = 8'h30;
    localparam logic [AW-1:0] PT_CMD_PID     = 8'h41;
    localparam logic [AW-1:0] PT_CMD_COMFLT  = 8'h5a;
    localparam logic [AW-1:0] PT_CMD_FRESET  = 8'h5e;
    localparam logic [AW-1:0] PT_CMD_EXTTRIP = 8'h60;
    localparam int CB_REV = 0;
    localparam int CB_RUN = 1;
    localparam int CB_DAYNGT = 2;
    localparam int CB_LOCK = 3;
    localparam int CB_ENABLE = 4;
    localparam int CB_MFI1 = 5;
    localparam int CB_PID = 10;
    localparam int CB_COMFLT = 11;
    localparam int CB_FRESET = 12;
    localparam int CB_EXTTRIP = 13;
    localparam logic [NCMD-1:0] CMD_RESET = 14'h0800;

    // ------------
    // mailbox points and interrupt registers
    // ------------
    localparam logic [AW-1:0] PT_RD_SEL   = 8'h46;
    localparam logic [AW-1:0] PT_RD_VAL   = 8'h47;
    localparam logic [AW-1:0] PT_WR_SEL   = 8'h48;
    localparam logic [AW-1:0] PT_WR_VAL   = 8'h49;
    localparam logic [AW-1:0] PT_IRQ_STAT = 8'hf0;
    localparam logic [AW-1:0] PT_IRQ_MASK = 8'hf1;
    localparam int NIRQ = 4;
    localparam int EV_MB_OK = 0;
    localparam int EV_MB_REJ = 1;
    localparam int EV_MAJOR = 2;
    localparam int EV_KP_REJ = 3;
    localparam logic [NIRQ-1:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [DW-1:0] PARAM_RESET = 16'h0000;
endpackage : npm_pkg

/* File: design/npm_store_if.sv */
`timescale 1ns/1ps
interface npm_store_if;
    import npm_pkg::*;
    logic          mb_wr;
    logic [NW-1:0] mb_num;
    logic [DW-1:0] mb_data;
    logic          kp_wr;
    logic [NW-1:0] kp_num;
    logic [DW-1:0] kp_data;
    logic          running;
    logic          mb_ok;
    logic          kp_ok;
    logic [NW-1:0] rd_num;
    logic [DW-1:0] rd_data;
    modport master (output mb_wr, mb_num, mb_data, kp_wr, kp_num, kp_data, running, rd_num,
                    input mb_ok, kp_ok, rd_data);
    modport store  (input mb_wr, mb_num, mb_data, kp_wr, kp_num, kp_data, running, rd_num,
                    output mb_ok, kp_ok, rd_data);
endinterface : npm_store_if

/* File: design/npm_param_store.sv */
`timescale 1ns/1ps
module npm_param_store #(
    parameter int                      DEPTH      = 64,
    parameter logic [DEPTH-1:0]        RUN_WR_MAP = '0
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    npm_store_if.store st
);
    import npm_pkg::*;

    logic [DW-1:0] param_ff [DEPTH];

    // ------------
    // acceptance check shared by keypad and mailbox
    // ------------
    function automatic logic accept(input logic [NW-1:0] num, input logic running);
        logic ok;
        ok = 1'b0;
        if (num < NW'(DEPTH)) begin
            ok = !running || RUN_WR_MAP[num[$clog2(DEPTH)-1:0]];
        end
        return ok;
    endfunction : accept

    assign st.mb_ok = st.mb_wr && accept(st.mb_num, st.running);
    assign st.kp_ok = st.kp_wr && accept(st.kp_num, st.running);

    // out-of-range numbers read as zero rather than aliasing
    assign st.rd_data = (st.rd_num < NW'(DEPTH)) ? param_ff[st.rd_num[$clog2(DEPTH)-1:0]] : '0;

    // ------------
    // storage; mailbox lands last on a same-cycle collision
    // ------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                param_ff[i] <= PARAM_RESET;
            end
        end else begin
            if (st.kp_ok) begin
                param_ff[st.kp_num[$clog2(DEPTH)-1:0]] <= st.kp_data;
            end
            if (st.mb_ok) begin
                param_ff[st.mb_num[$clog2(DEPTH)-1:0]] <= st.mb_data;
            end
        end
    end
endmodule : npm_param_store

/* File: design/npm_point_map.sv */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module npm_point_map #(
    parameter int                 DEPTH      = 64,
    parameter logic [DEPTH-1:0]   RUN_WR_MAP = '0
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic [npm_pkg::AW-1:0]   pt_addr,
    input  wire logic [npm_pkg::DW-1:0]   pt_wdata,
    input  wire logic                     pt_wr,
    input  wire logic                     pt_rd,
    output logic      [npm_pkg::DW-1:0]   pt_rdata,
    input  wire logic [7:0]               drive_status_word_monitor,
    input  wire logic [7:0]               input_terminal_monitor,
    input  wire logic [7:0]               output_terminal_monitor,
    input  wire logic                     local_mode,
    input  wire logic                     safety_interlock,
    input  wire logic                     drive_comm_error,
    input  wire logic                     kp_wr,
    input  wire logic [npm_pkg::NW-1:0]   kp_num,
    input  wire logic [npm_pkg::DW-1:0]   kp_data,
    output logic                          kp_reject,
    output logic                          run_command,
    output logic                          reverse_run_command,
    output logic                          day_night,
    output logic                          panel_lock,
    output logic                          run_enable,
    output logic      [4:0]               multi_function_in,
    output logic                          pid_mode_param,
    output logic                          comm_fault_detect_param,
    output logic                          fault_reset_n,
    output logic                          external_trip_command_n,
    output logic                          irq
);
    import npm_pkg::*;

    npm_store_if sif ();

    logic [NCMD-1:0] cmd_ff;
    logic [NW-1:0]   rd_sel_ff;
    logic [NW-1:0]   wr_sel_ff;
    logic [DW-1:0]   wr_val_ff;
    logic [DW-1:0]   rdata_ff;
    logic            kp_reject_ff;
    logic [NIRQ-1:0] irq_stat_ff;
    logic [NIRQ-1:0] irq_mask_ff;
    logic            irq_ff;
    logic            major_ff;
    logic [DW-1:0]   nxt_rdata;
    logic [NIRQ-1:0] nxt_irq_stat;
    logic [NIRQ-1:0] events;
    logic            status_bit;
    logic            status_hit;

    // ------------
    // parameter store
    // ------------
    assign sif.mb_wr   = pt_wr && (pt_addr == PT_WR_VAL);
    assign sif.mb_num  = wr_sel_ff;
    assign sif.mb_data = pt_wdata;
    assign sif.kp_wr   = kp_wr;
    assign sif.kp_num  = kp_num;
    assign sif.kp_data = kp_data;
    assign sif.running = drive_status_word_monitor[SW_RUN];
    assign sif.rd_num  = rd_sel_ff;

    npm_param_store #(
        .DEPTH      (DEPTH),
        .RUN_WR_MAP (RUN_WR_MAP)
    ) u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .st      (sif.store)
    );

    // ------------
    // status point decode
    // ------------
    always_comb begin
        status_hit = 1'b1;
        case (pt_addr)
            PT_MINOR_FLT:   status_bit = drive_status_word_monitor[SW_MINOR];
            PT_MAJOR_FLT:   status_bit = drive_status_word_monitor[SW_MAJOR];
            PT_OK_FAULT:    status_bit = drive_status_word_monitor[SW_MAJOR];
            PT_DIRECTION:   status_bit = drive_status_word_monitor[SW_REV];
            PT_RUN_STATE:   status_bit = drive_status_word_monitor[SW_RUN];
            PT_ZERO_SPEED:  status_bit = drive_status_word_monitor[SW_ZERO];
            PT_SPEED_AGREE: status_bit = drive_status_word_monitor[SW_AGREE];
            PT_READY:       status_bit = drive_status_word_monitor[SW_READY];
            PT_LOCAL_MODE:  status_bit = local_mode;
            PT_OUT_TERM1:   status_bit = output_terminal_monitor[OT_BIT1];
            PT_OUT_TERM2:   status_bit = output_terminal_monitor[OT_BIT1+1];
            PT_OUT_TERM3:   status_bit = output_terminal_monitor[OT_BIT1+2];
            PT_SAFETY:      status_bit = safety_interlock;
            PT_IN_TERM1:    status_bit = input_terminal_monitor[IT_BIT1];
            PT_IN_TERM2:    status_bit = input_terminal_monitor[IT_BIT1+1];
            PT_IN_TERM3:    status_bit = input_terminal_monitor[IT_BIT1+2];
            PT_IN_TERM4:    status_bit = input_terminal_monitor[IT_BIT1+3];
            PT_IN_TERM5:    status_bit = input_terminal_monitor[IT_BIT1+4];
            PT_COMM_ERR:    status_bit = drive_comm_error;
            default: begin
                status_bit = 1'b0;
                status_hit = 1'b0;
            end
        endcase
    end

    // ------------
    // read data, valid only in the cycle after the strobe
    // ------------
    always_comb begin
        nxt_rdata = '0;
        if (status_hit) begin
            nxt_rdata = {{(DW-1){1'b0}}, status_bit};
        end else begin
            case (pt_addr)
                PT_CMD_REV:     nxt_rdata = DW'(cmd_ff[CB_REV]);
                PT_CMD_RUN:     nxt_rdata = DW'(cmd_ff[CB_RUN]);
                PT_CMD_DAYNGT:  nxt_rdata = DW'(cmd_ff[CB_DAYNGT]);
                PT_CMD_LOCK:    nxt_rdata = DW'(cmd_ff[CB_LOCK]);
                PT_CMD_ENABLE:  nxt_rdata = DW'(cmd_ff[CB_ENABLE]);
                PT_CMD_PID:     nxt_rdata = DW'(cmd_ff[CB_PID]);
                PT_CMD_COMFLT:  nxt_rdata = DW'(cmd_ff[CB_COMFLT]);
                PT_CMD_FRESET:  nxt_rdata = DW'(cmd_ff[CB_FRESET]);
                PT_CMD_EXTTRIP: nxt_rdata = DW'(cmd_ff[CB_EXTTRIP]);
                PT_RD_SEL:      nxt_rdata = rd_sel_ff;
                PT_RD_VAL:      nxt_rdata = sif.rd_data;
                PT_WR_SEL:      nxt_rdata = wr_sel_ff;
                PT_WR_VAL:      nxt_rdata = wr_val_ff;
                PT_IRQ_STAT:    nxt_rdata = DW'(irq_stat_ff);
                PT_IRQ_MASK:    nxt_rdata = DW'(irq_mask_ff);
                default: begin
                    if (pt_addr >= PT_CMD_MFI1 && pt_addr <= PT_CMD_MFI5) begin
                        nxt_rdata = DW'(cmd_ff[CB_MFI1 + int'(pt_addr - PT_CMD_MFI1)]);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (pt_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= '0;
        end
    end

    // ------------
    // command points; only bit 0 of the write data counts
    // ------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_ff <= CMD_RESET;
        end else if (pt_wr) begin
            case (pt_addr)
                PT_CMD_REV:     cmd_ff[CB_REV]     <= pt_wdata[0];
                PT_CMD_RUN:     cmd_ff[CB_RUN]     <= pt_wdata[0];
                PT_CMD_DAYNGT:  cmd_ff[CB_DAYNGT]  <= pt_wdata[0];
                PT_CMD_LOCK:    cmd_ff[CB_LOCK]    <= pt_wdata[0];
                PT_CMD_ENABLE:  cmd_ff[CB_ENABLE]  <= pt_wdata[0];
                PT_CMD_PID:     cmd_ff[CB_PID]     <= pt_wdata[0];
                PT_CMD_COMFLT:  cmd_ff[CB_COMFLT]  <= pt_wdata[0];
                PT_CMD_FRESET:  cmd_ff[CB_FRESET]  <= pt_wdata[0];
                PT_CMD_EXTTRIP: cmd_ff[CB_EXTTRIP] <= pt_wdata[0];
                default: begin
                    if (pt_addr >= PT_CMD_MFI1 && pt_addr <= PT_CMD_MFI5) begin
                        cmd_ff[CB_MFI1 + int'(pt_addr - PT_CMD_MFI1)] <= pt_wdata[0];
                    end
                end
            endcase
        end
    end

    // ------------
    // mailbox selects and last written value
    // ------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_sel_ff <= '0;
            wr_sel_ff <= '0;
            wr_val_ff <= '0;
        end else if (pt_wr) begin
            if (pt_addr == PT_RD_SEL) begin
                rd_sel_ff <= pt_wdata;
            end
            if (pt_addr == PT_WR_SEL) begin
                wr_sel_ff <= pt_wdata;
            end
            if (pt_addr == PT_WR_VAL) begin
                wr_val_ff <= pt_wdata;
            end
        end
    end

    // ------------
    // interrupts: sticky, cleared by reading, set wins over clear
    // ------------
    assign events[EV_MB_OK]  = sif.mb_ok;
    assign events[EV_MB_REJ] = sif.mb_wr && !sif.mb_ok;
    assign events[EV_MAJOR]  = drive_status_word_monitor[SW_MAJOR] && !major_ff;
    assign events[EV_KP_REJ] = kp_wr && !sif.kp_ok;

    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (pt_rd && pt_addr == PT_IRQ_STAT) begin
            nxt_irq_stat = '0;
        end
        nxt_irq_stat = nxt_irq_stat | events;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_ff  <= '0;
            irq_mask_ff  <= IRQ_MASK_RESET;
            irq_ff       <= 1'b0;
            major_ff     <= 1'b0;
            kp_reject_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (pt_wr && pt_addr == PT_IRQ_MASK) begin
                irq_mask_ff <= pt_wdata[NIRQ-1:0];
            end
            // one cycle late relative to status; keeps the output a plain flop
            irq_ff       <= |(irq_stat_ff & irq_mask_ff);
            major_ff     <= drive_status_word_monitor[SW_MAJOR];
            kp_reject_ff <= events[EV_KP_REJ];
        end
    end

    // ------------
    // outputs
    // ------------
    assign pt_rdata                = rdata_ff;
    assign kp_reject               = kp_reject_ff;
    assign irq                     = irq_ff;
    assign run_command             = cmd_ff[CB_RUN];
    assign reverse_run_command     = cmd_ff[CB_REV];
    assign day_night               = cmd_ff[CB_DAYNGT];
    assign panel_lock              = cmd_ff[CB_LOCK];
    assign run_enable              = cmd_ff[CB_ENABLE];
    assign multi_function_in       = cmd_ff[CB_MFI1 +: 5];
    assign pid_mode_param          = cmd_ff[CB_PID];
    assign comm_fault_detect_param = cmd_ff[CB_COMFLT];
    assign fault_reset_n           = cmd_ff[CB_FRESET];
    assign external_trip_command_n = cmd_ff[CB_EXTTRIP];
endmodule : npm_point_map

/* File: tb/npm_point_map_sva.sv */
`timescale 1ns/1ps
module npm_point_map_sva #(
    parameter int               DEPTH      = 64,
    parameter logic [DEPTH-1:0] RUN_WR_MAP = '0
) (
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic [npm_pkg::AW-1:0] pt_addr,
    input wire logic [npm_pkg::DW-1:0] pt_wdata,
    input wire logic                   pt_wr,
    input wire logic                   pt_rd,
    input wire logic [npm_pkg::DW-1:0] pt_rdata,
    input wire logic [7:0]             drive_status_word_monitor,
    input wire logic                   kp_wr,
    input wire logic [npm_pkg::NW-1:0] kp_num,
    input wire logic [npm_pkg::DW-1:0] kp_data,
    input wire logic                   kp_reject,
    input wire logic                   run_command,
    input wire logic                   external_trip_command_n
);
    import npm_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------
    // shadow of the parameter store
    // ------------
    logic [DW-1:0] shadow_ff [DEPTH];
    logic [DW-1:0] rd_sel_ff;
    logic [DW-1:0] wr_sel_ff;
    logic          kp_refuse;
    logic          mb_refuse;
    logic [DW-1:0] rd_val_exp;
    wire           running = drive_status_word_monitor[SW_RUN];
    assign kp_refuse  = (kp_num >= DEPTH) || (running && !RUN_WR_MAP[kp_num]);
    assign mb_refuse  = (wr_sel_ff >= DEPTH) || (running && !RUN_WR_MAP[wr_sel_ff]);
    assign rd_val_exp = (rd_sel_ff < DEPTH) ? shadow_ff[rd_sel_ff] : '0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_sel_ff <= '0;
            wr_sel_ff <= '0;
            for (int i = 0; i < DEPTH; i++) shadow_ff[i] <= PARAM_RESET;
        end else begin
            if (pt_wr && pt_addr == PT_RD_SEL) rd_sel_ff <= pt_wdata;
            if (pt_wr && pt_addr == PT_WR_SEL) wr_sel_ff <= pt_wdata;
            if (kp_wr && !kp_refuse) shadow_ff[kp_num] <= kp_data;
            // mailbox assigned last: it wins a same-index collision
            if (pt_wr && pt_addr == PT_WR_VAL && !mb_refuse) shadow_ff[wr_sel_ff] <= pt_wdata;
        end
    end
    a_run_point_read: assert property (
        pt_rd && pt_addr == PT_RUN_STATE |=> pt_rdata[0] == $past(drive_status_word_monitor[SW_RUN]))
        else $error("run point read");
    a_major_point_read: assert property (
        pt_rd && pt_addr == PT_MAJOR_FLT |=> pt_rdata[0] == $past(drive_status_word_monitor[SW_MAJOR]))
        else $error("major point read");
    a_rdata_idle_zero: assert property (!pt_rd |=> pt_rdata == '0)
        else $error("read data not idle");
    a_run_cmd_write: assert property (
        pt_wr && pt_addr == PT_CMD_RUN |=> run_command == $past(pt_wdata[0]))
        else $error("run command not taken");
    a_trip_cmd_write: assert property (
        pt_wr && pt_addr == PT_CMD_EXTTRIP |=> external_trip_command_n == $past(pt_wdata[0]))
        else $error("trip command not taken");
    a_kp_refusal_rule: assert property (kp_wr |=> kp_reject == $past(kp_refuse))
        else $error("keypad acceptance wrong");
    a_kp_reject_cause: assert property (kp_reject |-> $past(kp_wr))
        else $error("keypad reject without write");
    a_mbox_read_value: assert property (
        pt_rd && pt_addr == PT_RD_VAL |=> pt_rdata == $past(rd_val_exp))
        else $error("mailbox read value wrong");
    c_mbox_read: cover property (pt_rd && pt_addr == PT_RD_VAL);
    c_mbox_refused: cover property (pt_wr && pt_addr == PT_WR_VAL && mb_refuse);
    c_kp_refused: cover property (kp_reject);
endmodule : npm_point_map_sva

bind npm_point_map npm_point_map_sva #(.DEPTH(DEPTH), .RUN_WR_MAP(RUN_WR_MAP)) chk (
    .ref_clk(ref_clk), .rst(rst), .pt_addr(pt_addr), .pt_wdata(pt_wdata), .pt_wr(pt_wr),
    .pt_rd(pt_rd), .pt_rdata(pt_rdata), .drive_status_word_monitor(drive_status_word_monitor),
    .kp_wr(kp_wr), .kp_num(kp_num), .kp_data(kp_data), .kp_reject(kp_reject),
    .run_command(run_command), .external_trip_command_n(external_trip_command_n));

/* File: tb/npm_ctl_model.sv */
`timescale 1ns/1ps
module npm_ctl_model (
    input  wire logic                   ref_clk,
    output logic      [npm_pkg::AW-1:0] pt_addr,
    output logic      [npm_pkg::DW-1:0] pt_wdata,
    output logic                        pt_wr,
    output logic                        pt_rd,
    input  wire logic [npm_pkg::DW-1:0] pt_rdata
);
    import npm_pkg::*;
    initial {pt_addr, pt_wdata, pt_wr, pt_rd} = 26'h0;
    // ------------
    // bus cycles; idle lines show the inverse so stale values never pass
    // ------------
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        pt_addr <= a;
        pt_wdata <= d;
        pt_wr <= 1'b1;
        @(posedge ref_clk);
        pt_wr <= 1'b0;
        pt_addr <= ~a;
        pt_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge ref_clk);
        pt_addr <= a;
        pt_rd <= 1'b1;
        @(posedge ref_clk);
        pt_rd <= 1'b0;
        pt_addr <= ~a;
        #1;
        d = pt_rdata;
    endtask : rd
    task automatic mb_write(input logic [DW-1:0] num, input logic [DW-1:0] v);
        wr(PT_WR_SEL, num);
        wr(PT_WR_VAL, v);
    endtask : mb_write
    task automatic mb_read(input logic [DW-1:0] num, output logic [DW-1:0] v);
        wr(PT_RD_SEL, num);
        rd(PT_RD_VAL, v);
    endtask : mb_read
endmodule : npm_ctl_model

/* File: tb/test_network_point_mailbox_map.sv */
`timescale 1ns/1ps
module test_network_point_mailbox_map;
    import npm_pkg::*;
    logic ref_clk, rst, kp_wr, kp_reject, irq, pt_wr, pt_rd;
    logic local_mode, safety_interlock, drive_comm_error;
    logic [7:0] status, itm, otm;
    logic [AW-1:0] pt_addr;
    logic [DW-1:0] pt_wdata, pt_rdata, kp_num, kp_data;
    logic run_command, reverse_run_command, day_night, panel_lock, run_enable, pid_mode_param;
    logic comm_fault_detect_param, fault_reset_n, external_trip_command_n;
    logic [4:0] multi_function_in;
    logic [13:0] cmd_vec;
    int failures = 0, comparisons = 0, cycles = 0;
    logic [7:0] spt [8] = '{PT_RUN_STATE, PT_ZERO_SPEED, PT_DIRECTION, PT_SPEED_AGREE,
                            PT_READY, PT_MINOR_FLT, PT_MAJOR_FLT, PT_OK_FAULT};
    int sbit [8] = '{0, 1, 2, 4, 5, 6, 7, 7};
    logic [7:0] cpt [14] = '{PT_CMD_REV, PT_CMD_RUN, PT_CMD_DAYNGT, PT_CMD_LOCK, PT_CMD_ENABLE,
                             PT_CMD_MFI1, 8'h2d, 8'h2e, 8'h2f, PT_CMD_MFI5, PT_CMD_PID,
                             PT_CMD_COMFLT, PT_CMD_FRESET, PT_CMD_EXTTRIP};
    logic [7:0] xpt [11] = '{PT_LOCAL_MODE, PT_SAFETY, PT_COMM_ERR, PT_OUT_TERM1, PT_OUT_TERM2, PT_OUT_TERM3,
                             PT_IN_TERM1, PT_IN_TERM2, PT_IN_TERM3, PT_IN_TERM4, PT_IN_TERM5};
    assign cmd_vec = {external_trip_command_n, fault_reset_n, comm_fault_detect_param, pid_mode_param,
                      multi_function_in, run_enable, panel_lock, day_night, run_command, reverse_run_command};
    npm_point_map #(.DEPTH(64), .RUN_WR_MAP(64'h20)) uut (
        .ref_clk(ref_clk), .rst(rst), .pt_addr(pt_addr), .pt_wdata(pt_wdata), .pt_wr(pt_wr),
        .pt_rd(pt_rd), .pt_rdata(pt_rdata), .drive_status_word_monitor(status),
        .input_terminal_monitor(itm), .output_terminal_monitor(otm), .local_mode(local_mode),
        .safety_interlock(safety_interlock), .drive_comm_error(drive_comm_error), .kp_wr(kp_wr),
        .kp_num(kp_num), .kp_data(kp_data), .kp_reject(kp_reject), .run_command(run_command),
        .reverse_run_command(reverse_run_command), .day_night(day_night), .panel_lock(panel_lock),
        .run_enable(run_enable), .multi_function_in(multi_function_in), .pid_mode_param(pid_mode_param),
        .comm_fault_detect_param(comm_fault_detect_param), .fault_reset_n(fault_reset_n),
        .external_trip_command_n(external_trip_command_n), .irq(irq));
    npm_ctl_model ctl (.ref_clk(ref_clk), .pt_addr(pt_addr), .pt_wdata(pt_wdata), .pt_wr(pt_wr),
                       .pt_rd(pt_rd), .pt_rdata(pt_rdata));
    // ------------
    // checking and closing
    // ------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic kp(input logic [15:0] n, input logic [15:0] v, input logic exp);
        @(posedge ref_clk);
        kp_wr <= 1'b1;
        kp_num <= n;
        kp_data <= v;
        @(posedge ref_clk);
        kp_wr <= 1'b0;
        #1;
        check("keypad reject", {15'h0, kp_reject}, {15'h0, exp});
    endtask : kp
    // ------------
    // scenarios
    // ------------
    task automatic t_status;
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk) status <= 8'h01 << sbit[i];
            ctl.rd(spt[i], d);
            check("status point set", d, 16'h0001);
            @(posedge ref_clk) status <= ~(8'h01 << sbit[i]);
            ctl.rd(spt[i], d);
            check("status point clear", d, 16'h0000);
        end
        for (int i = 0; i < 22; i++) begin
            @(posedge ref_clk) {local_mode, safety_interlock, drive_comm_error, otm, itm} <= {19{i[0]}} ^ 19'h7077c;
            ctl.rd(xpt[i/2], d);
            check("terminal point", d, {15'h0, !i[0]});
        end
        @(posedge ref_clk) status <= 8'h00;
        ctl.rd(8'h00, d);
        check("unmapped read", d, 16'h0000);
    endtask : t_status
    task automatic t_cmds;
        logic [15:0] d;
        check("command defaults", {2'b00, cmd_vec}, 16'h0800);
        for (int i = 0; i < 14; i++) begin
            ctl.wr(cpt[i], 16'h0001);
            check("command set", {15'h0, cmd_vec[i]}, 16'h0001);
            ctl.rd(cpt[i], d);
            check("command readback", d, 16'h0001);
            ctl.wr(cpt[i], 16'h0000);
            check("command clear", {15'h0, cmd_vec[i]}, 16'h0000);
        end
    endtask : t_cmds
    task automatic t_mailbox;
        logic [15:0] d;
        ctl.wr(PT_IRQ_MASK, 16'h0001);
        ctl.mb_write(16'd3, 16'h1234);
        ctl.mb_read(16'd3, d);
        check("mailbox param 3", d, 16'h1234);
        check("irq after accept", {15'h0, irq}, 16'h0001);
        ctl.rd(PT_IRQ_STAT, d);
        check("status accept bit", d, 16'h0005);
        @(posedge ref_clk) #1;
        check("irq after clear", {15'h0, irq}, 16'h0000);
    endtask : t_mailbox
    task automatic t_running;
        logic [15:0] d;
        ctl.wr(PT_IRQ_MASK, 16'h0002);
        @(posedge ref_clk) status <= 8'h01;
        ctl.mb_write(16'd3, 16'h5555);
        ctl.mb_read(16'd3, d);
        check("refused keeps value", d, 16'h1234);
        check("irq on refusal", {15'h0, irq}, 16'h0001);
        ctl.mb_write(16'd5, 16'h00a5);
        ctl.mb_read(16'd5, d);
        check("run-writable param", d, 16'h00a5);
        ctl.mb_write(16'd64, 16'h7777);
        ctl.mb_read(16'd64, d);
        check("out of range param", d, 16'h0000);
        ctl.rd(PT_IRQ_STAT, d);
        check("status both bits", d, 16'h0003);
        kp(16'd3, 16'h0bee, 1'b1);
        check("masked keypad irq", {15'h0, irq}, 16'h0000);
        @(posedge ref_clk) status <= 8'h00;
        kp(16'd3, 16'h0bee, 1'b0);
        ctl.mb_read(16'd3, d);
        check("keypad stored", d, 16'h0bee);
    endtask : t_running
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        {kp_wr, local_mode, safety_interlock, drive_comm_error} = 4'h0;
        {status, itm, otm} = 24'h000000;
        kp_num = 16'h0000;
        kp_data = 16'h0000;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_cmds();
        t_status();
        t_mailbox();
        t_running();
        test_done();
    end
endmodule : test_network_point_mailbox_map
